// file: bench/btfb_exec_tb.sv
// self-checking bench for the bit-invert and flag-branch executor
`timescale 1ns/1ps
module btfb_exec_tb;
  import btfb_pkg::*;
  logic              i_clk_sys = 1'b0;
  logic              i_srst = 1'b1;
  logic [15:0]       i_instr = 16'h0000;
  logic [BANK_W-1:0] i_bank_select_reg = 4'h0;
  logic              i_flag_overflow = 1'b0;
  logic              i_flag_zero = 1'b0;
  logic [7:0]        i_mem_rdata = 8'h00;
  logic [1:0]        o_phase;
  logic [PC_W-1:0]   o_pc;
  logic [ADDR_W-1:0] o_mem_addr;
  logic              o_mem_rd;
  logic              o_mem_wr;
  logic [7:0]        o_mem_wdata;
  logic              o_branch_taken;
  int                error_cnt = 0;
  int                n_compared = 0;

  always #5 i_clk_sys = ~i_clk_sys;

  btfb_exec btfb_exec_i (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_instr(i_instr),
    .i_bank_select_reg(i_bank_select_reg), .i_flag_overflow(i_flag_overflow),
    .i_flag_zero(i_flag_zero), .i_mem_rdata(i_mem_rdata), .o_phase(o_phase),
    .o_pc(o_pc), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
    .o_mem_wdata(o_mem_wdata), .o_branch_taken(o_branch_taken)
  );

  task automatic chk(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // returns at the edge that starts Q1
  task automatic sync();
    @(posedge i_clk_sys);
    while (o_phase !== PH_Q4) @(posedge i_clk_sys);
  endtask

  task automatic invert(input logic [2:0] b, input logic a, input logic [7:0] f,
                        input logic [3:0] bank, input logic [7:0] rd);
    logic [3:0] hi;
    hi = a ? bank : (f[7] ? 4'hf : 4'h0);
    sync();
    i_instr <= {4'h7, b, a, f};
    i_bank_select_reg <= bank;
    i_mem_rdata <= rd;
    repeat (3) @(posedge i_clk_sys);
    chk(PC_W'(o_mem_rd), 21'h1);
    chk(PC_W'(o_mem_addr), PC_W'({hi, f}));
    chk(PC_W'(o_phase), PC_W'(PH_Q3));
    @(posedge i_clk_sys);
    i_instr <= 16'h0000;
    chk(PC_W'(o_mem_rd), 21'h0);
    chk(PC_W'({o_mem_wr, o_mem_wdata}), PC_W'({1'b1, rd ^ (8'h01 << b)}));
  endtask

  task automatic br(input logic [15:0] w, input logic ov, input logic z, input logic tk);
    logic [PC_W-1:0] pc0;
    logic [PC_W-1:0] tgt;
    sync();
    i_instr <= w;
    i_flag_overflow <= ov;
    i_flag_zero <= z;
    @(posedge i_clk_sys);
    pc0 = o_pc;
    tgt = pc0 + PC_STEP + (tk ? {{12{w[7]}}, w[7:0], 1'b0} : 21'h0);
    repeat (3) @(posedge i_clk_sys);
    // a bit-invert word offered in the idle cycle must be dropped
    i_instr <= tk ? 16'h7a55 : 16'h0000;
    @(posedge i_clk_sys);
    chk(o_pc, tgt);
    chk(PC_W'(o_branch_taken), PC_W'(tk));
    if (tk) begin
      repeat (3) begin
        @(posedge i_clk_sys);
        chk(PC_W'({o_mem_rd, o_mem_wr}), 21'h0);
      end
      chk(o_pc, tgt);
      i_instr <= 16'h0000;
      @(posedge i_clk_sys);
      chk(o_pc, tgt);
    end
  endtask

  // reset in mid-instruction, then the first word after release steps the counter
  task automatic mid_reset();
    sync();
    i_instr <= 16'he47f;
    i_flag_overflow <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    chk(o_pc, PC_RESET);
    chk(PC_W'({o_phase, o_mem_rd, o_mem_wr, o_branch_taken}), PC_W'({PH_Q1, 3'h0}));
    i_srst <= 1'b0;
    i_instr <= 16'h0000;
    repeat (5) @(posedge i_clk_sys);
    chk(o_pc, PC_RESET + PC_STEP);
  endtask

  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    for (int b = 0; b < 8; b++) invert(3'(b), b[0], {b[1], 7'h35}, 4'h9, 8'h75);
    br(16'he47f, 1'b1, 1'b0, 1'b1);
    br(16'he480, 1'b0, 1'b1, 1'b0);
    br(16'he080, 1'b0, 1'b1, 1'b1);
    br(16'he005, 1'b1, 1'b0, 1'b0);
    br(16'h0000, 1'b1, 1'b1, 1'b0);
    br(16'he0fe, 1'b1, 1'b1, 1'b1);
    mid_reset();
    test_done();
  end

  initial begin
    #50000;
    error_cnt++;
    test_done();
  end
endmodule // btfb_exec_tb

// file: include/btfb_pkg.sv
// constants and decode helpers for the bit-invert and flag-branch executor
// What this block does
// - top nibble 0111 decodes bit invert: bit number, bank selector, file address
// - bit invert reads byte, flips only chosen bit, writes back same place
// - selector 0 uses fixed access bank; selector 1 uses bank select register
// - these three instructions never change any arithmetic status flag
// - upper byte 1110 0100 decodes branch on overflow, low byte signed offset
// - upper byte 1110 0000 decodes branch on zero, low byte signed offset
// - branch on overflow changes program counter only when overflow flag is 1
// - branch on zero changes program counter only when zero flag is 1
// - target is incremented counter plus twice the signed offset
// - untaken branch takes one cycle; taken takes two, second is idle
package btfb_pkg;
  localparam int unsigned PC_W        = 21;
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned BANK_W      = 4;
  localparam logic [3:0]  OPC_INVERT  = 4'h7;
  localparam logic [7:0]  OPC_BOV     = 8'he4;
  localparam logic [7:0]  OPC_BZ      = 8'he0;
  localparam int unsigned BIT_LSB     = 9;
  localparam int unsigned BANK_SEL    = 8;
  localparam logic [BANK_W-1:0] ACC_LO_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACC_HI_BANK = 4'hf;
  localparam int unsigned ACC_SPLIT_BIT = 7;
  localparam logic [PC_W-1:0]   PC_STEP     = 21'h000002;
  localparam logic [PC_W-1:0]   PC_RESET    = 21'h000000;
  localparam logic [1:0]  PH_Q1 = 2'h0;
  localparam logic [1:0]  PH_Q2 = 2'h1;
  localparam logic [1:0]  PH_Q3 = 2'h2;
  localparam logic [1:0]  PH_Q4 = 2'h3;

  function automatic logic is_invert(input logic [15:0] w);
    return w[15:12] == OPC_INVERT;
  endfunction

  function automatic logic is_bov(input logic [15:0] w);
    return w[15:8] == OPC_BOV;
  endfunction

  function automatic logic is_bz(input logic [15:0] w);
    return w[15:8] == OPC_BZ;
  endfunction

  function automatic logic [7:0] bit_mask(input logic [15:0] w);
    return 8'h01 << w[BIT_LSB+:3];
  endfunction

  function automatic logic [ADDR_W-1:0] data_addr(input logic [15:0]       w,
                                                 input logic [BANK_W-1:0] bank);
    logic [BANK_W-1:0] hi;
    hi = w[BANK_SEL] ? bank : (w[ACC_SPLIT_BIT] ? ACC_HI_BANK : ACC_LO_BANK);
    return {hi, w[7:0]};
  endfunction

  function automatic logic [PC_W-1:0] branch_disp(input logic [15:0] w);
    logic [PC_W-1:0] sx;
    sx = {{(PC_W-8){w[7]}}, w[7:0]};
    return {sx[PC_W-2:0], 1'b0};
  endfunction
endpackage

// file: rtl/btfb_exec.sv
// executor for bit invert, branch on overflow and branch on zero
`timescale 1ns/1ps
module btfb_exec
  import btfb_pkg::*;
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_srst,
  input  wire logic [15:0]       i_instr,
  input  wire logic [BANK_W-1:0] i_bank_select_reg,
  input  wire logic              i_flag_overflow,
  input  wire logic              i_flag_zero,
  input  wire logic [7:0]        i_mem_rdata,
  output logic [1:0]             o_phase,
  output logic [PC_W-1:0]        o_pc,
  output logic [ADDR_W-1:0]      o_mem_addr,
  output logic                   o_mem_rd,
  output logic                   o_mem_wr,
  output logic [7:0]             o_mem_wdata,
  output logic                   o_branch_taken
);
  logic [1:0]      phase;
  logic [15:0]     ir;
  logic            ir_live;
  logic            flush;
  logic            taken;
  logic [PC_W-1:0] target;

  btfb_phase_gen btfb_phase_gen_i (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .o_phase   (phase)
  );

  wire             q1       = phase == PH_Q1;
  wire             q2       = phase == PH_Q2;
  wire             q3       = phase == PH_Q3;
  wire             q4       = phase == PH_Q4;
  wire             do_inv   = ir_live && is_invert(ir);
  wire             do_bov   = ir_live && is_bov(ir);
  wire             do_bz    = ir_live && is_bz(ir);
  // flags are only sampled here, never written back
  wire             cond_ok  = (do_bov && i_flag_overflow)
                           || (do_bz && i_flag_zero);
  wire [PC_W-1:0]  next_pc_seq = o_pc + PC_STEP;
  wire [PC_W-1:0]  next_target = next_pc_seq + branch_disp(ir);
  // an idle slot holds the counter, so the word at the target is fetched again
  wire [PC_W-1:0]  next_pc     = taken ? target : (ir_live ? next_pc_seq : o_pc);
  wire [7:0]       next_wdata  = i_mem_rdata ^ bit_mask(ir);
  wire [ADDR_W-1:0] next_addr  = data_addr(ir, i_bank_select_reg);

  assign o_phase = phase;

  // instruction capture; a flushed slot becomes an idle cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ir      <= 16'h0000;
      ir_live <= 1'b0;
    end else if (q1) begin
      ir      <= i_instr;
      ir_live <= !flush;
    end
  end

  // data memory read-modify-write, write in the last phase
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_mem_addr  <= '0;
      o_mem_rd    <= 1'b0;
      o_mem_wr    <= 1'b0;
      o_mem_wdata <= 8'h00;
    end else begin
      o_mem_rd <= q2 && do_inv;
      o_mem_wr <= q3 && do_inv;
      if (q2 && do_inv) begin
        o_mem_addr <= next_addr;
      end
      if (q3 && do_inv) begin
        o_mem_wdata <= next_wdata;
      end
    end
  end

  // branch decision in processing phase, counter written in last phase
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      taken  <= 1'b0;
      target <= PC_RESET;
    end else if (q3) begin
      taken  <= cond_ok;
      target <= next_target;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_pc           <= PC_RESET;
      flush          <= 1'b0;
      o_branch_taken <= 1'b0;
    end else begin
      o_branch_taken <= q4 && taken;
      if (q4) begin
        o_pc  <= next_pc;
        flush <= taken;
      end else if (q1) begin
        flush <= 1'b0;
      end
    end
  end

  // checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);

  a_invert_read_addr: assert property (
    (q2 && ir_live && is_invert(ir)) |=>
      (o_mem_rd && o_mem_addr == data_addr(ir, $past(i_bank_select_reg)) && q3))
    else $error("bit invert read address or strobe wrong");

  a_invert_one_bit: assert property (
    (q3 && o_mem_rd) |=>
      (o_mem_wr && q4 && ((o_mem_wdata ^ $past(i_mem_rdata)) == bit_mask(ir))))
    else $error("bit invert changed wrong bits");

  a_access_bank: assert property (
    (o_mem_rd && !ir[BANK_SEL]) |->
      (o_mem_addr[ADDR_W-1:8] == (ir[ACC_SPLIT_BIT] ? ACC_HI_BANK : ACC_LO_BANK)))
    else $error("access bank not used with selector clear");

  a_bz_target: assert property (
    (q3 && ir_live && is_bz(ir) && i_flag_zero) |=> ##1
      (o_pc == $past(o_pc, 2) + PC_STEP + branch_disp(ir)))
    else $error("branch on zero target wrong");

  a_bov_taken: assert property (
    (q3 && ir_live && is_bov(ir) && i_flag_overflow) |=> ##1 o_branch_taken)
    else $error("branch on overflow not taken");

  a_branch_untaken: assert property (
    (q3 && ir_live && (is_bov(ir) || is_bz(ir))
       && !(is_bov(ir) ? i_flag_overflow : i_flag_zero)) |=> ##1
      (!o_branch_taken && o_pc == $past(o_pc, 2) + PC_STEP))
    else $error("untaken branch did not step sequentially");

  a_idle_slot: assert property (
    o_branch_taken |=> (!ir_live && !o_mem_rd && !o_mem_wr && !o_branch_taken) [*4])
    else $error("instruction after taken branch not discarded");

  a_pc_q4_only: assert property (
    (o_pc != $past(o_pc)) |-> $past(q4))
    else $error("program counter written outside last phase");

  a_no_write_nonop: assert property (
    (q3 && !(ir_live && is_invert(ir))) |=> !o_mem_wr)
    else $error("memory written by non invert instruction");

  // bit invert strobes and address
  a_read_pulse: assert property (
    o_mem_rd |=> (!o_mem_rd && o_mem_wr))
    else $error("read strobe not followed by write strobe");

  a_read_in_q3: assert property (
    o_mem_rd |-> (phase == PH_Q3))
    else $error("read strobe outside processing phase");

  a_write_in_q4: assert property (
    o_mem_wr |-> (phase == PH_Q4))
    else $error("write strobe outside last phase");

  a_write_same_addr: assert property (
    o_mem_wr |->
      ($stable(o_mem_addr) && !o_mem_rd))
    else $error("write back not to the byte that was read");

  a_bank_from_reg: assert property (
    (o_mem_rd && ir[BANK_SEL]) |->
      (o_mem_addr[ADDR_W-1:8] == $past(i_bank_select_reg)))
    else $error("bank select register not used with selector set");

  a_invert_no_branch: assert property (
    (q3 && ir_live && is_invert(ir)) |=> ##1
      !o_branch_taken)
    else $error("bit invert reported a taken branch");

  // branch timing and target
  a_bz_taken: assert property (
    (q3 && ir_live && is_bz(ir) && i_flag_zero) |=> ##1
      o_branch_taken)
    else $error("branch on zero not taken");

  a_bov_target: assert property (
    (q3 && ir_live && is_bov(ir) && i_flag_overflow) |=> ##1
      (o_pc == $past(o_pc, 2) + PC_STEP + branch_disp(ir)))
    else $error("branch on overflow target wrong");

  a_pc_even: assert property (
    o_pc[0] == 1'b0)
    else $error("program counter not word aligned");

  a_taken_pulse_q1: assert property (
    o_branch_taken |-> (phase == PH_Q1))
    else $error("taken pulse outside first phase");

  a_untaken_no_flush: assert property (
    (q4 && !taken) |=> !flush)
    else $error("untaken branch flushed next instruction");

  a_taken_flushes: assert property (
    (q4 && taken) |=> ##1
      !ir_live)
    else $error("taken branch kept the prefetched word");

  // the idle cycle must not move the counter off the target
  a_idle_pc_hold: assert property (
    o_branch_taken |=> ##3
      (o_pc == $past(o_pc, 4)))
    else $error("counter moved during idle cycle");

  c_invert_banked: cover property (o_mem_wr && ir[BANK_SEL]);
  c_invert_access: cover property (o_mem_wr && !ir[BANK_SEL]);
  c_bz_taken:      cover property (o_branch_taken && is_bz(ir));
  c_bov_taken:     cover property (o_branch_taken && is_bov(ir));
  c_back_to_back:  cover property (o_branch_taken ##7 (q4 && taken));
endmodule // btfb_exec

// file: rtl/btfb_phase_gen.sv
// four-phase instruction cycle sequencer
`timescale 1ns/1ps
module btfb_phase_gen
  import btfb_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_srst,
  output logic [1:0]      o_phase
);
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_phase <= PH_Q1;
    end else begin
      o_phase <= o_phase + 2'h1;
    end
  end
endmodule // btfb_phase_gen
